/* File: src/watchdog_regs.svh */
// register map, field positions, reset values and timing counts for the watchdog block
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define ADDR_OPTION_LATCH_TWO 16'h001E
`define ADDR_OPTION_LATCH_ONE 16'h001F
`define ADDR_WATCHDOG_SERVICE 16'hFFFF

// ----------------------------------------------------------------
// option latch two fields
// ----------------------------------------------------------------
`define BIT_OSC_IN_STOP_ENABLE 1
`define BIT_SERIAL_CLOCK_SOURCE 0

// ----------------------------------------------------------------
// option latch one fields
// ----------------------------------------------------------------
`define BIT_WATCHDOG_RATE_SELECT 7
`define BIT_DETECTOR_STOP_ENABLE 6
`define BIT_DETECTOR_RESET_DISABLE 5
`define BIT_DETECTOR_POWER_DISABLE 4
`define BIT_DETECTOR_VOLTAGE_MODE 3
`define BIT_SHORT_RECOVERY 2
`define BIT_STOP_ENABLE 1
`define BIT_WATCHDOG_DISABLE 0

// ----------------------------------------------------------------
// reset values and tied bits
// ----------------------------------------------------------------
`define OPTION_RESET_VALUE 8'h00
`define BYTE_ZERO 8'h00
`define DETECTOR_TIED_VALUE 1'b0
`define VOLTAGE_MODE_IMPLEMENTED 1'b0

// ----------------------------------------------------------------
// watchdog counts, in crystal clock cycles
// ----------------------------------------------------------------
`define PRESCALER_WIDTH 12
`define COUNTER_WIDTH 6
`define CHAIN_WIDTH 18
`define SHORT_CHAIN_WIDTH 13
`define TIMEOUT_LONG_CYCLES 18'h3FFF0
`define TIMEOUT_SHORT_CYCLES 13'h1FF0
`define SERVICE_KEEP_MASK 12'h00F
`define RESET_PIN_CYCLES 6'h20
`define POR_CLEAR_CYCLES 13'h1000

// ----------------------------------------------------------------
// stop recovery, in crystal clock cycles
// ----------------------------------------------------------------
`define RECOVERY_WIDTH 13
`define RECOVERY_SHORT_CYCLES 13'h0020
`define RECOVERY_LONG_CYCLES 13'h1000

// ----------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------
`define PIN_COUNT 2
`define PIN_RESET_IDX 0
`define PIN_IRQ_IDX 1

`endif

/* File: src/watchdog_pkg.sv */
// types shared by the watchdog block
package watchdog_pkg;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_STOP = 2'b01,
		MODE_RECOVER = 2'b10
	} power_mode_e;

	typedef logic [7:0] byte_t;

endpackage

/* File: src/pin_sync.sv */
// three-stage synchroniser for test-voltage detect pins
`timescale 1ns/100ps
`include "watchdog_regs.svh"

module pin_sync
	import watchdog_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [`PIN_COUNT-1:0] pin_async,
	output logic [`PIN_COUNT-1:0] pin_level
);

	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			// the level moves only when the two settled stages agree
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					pin_level[i] <= 1'b0;
				end else if (ce) begin
					s1_reg <= pin_async[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						pin_level[i] <= s3_reg;
					end
				end
			end
		end
	endgenerate

endmodule

/* File: src/stop_recovery.sv */
// stop-exit recovery delay counter
`timescale 1ns/100ps
`include "watchdog_regs.svh"

module stop_recovery
	import watchdog_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic use_long,
	output logic done
);

	logic [`RECOVERY_WIDTH-1:0] count_reg;
	logic [`RECOVERY_WIDTH-1:0] target_reg;
	logic busy_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count_reg <= '0;
			target_reg <= `RECOVERY_LONG_CYCLES;
			busy_reg <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				count_reg <= `RECOVERY_WIDTH'(1);
				target_reg <= use_long ? `RECOVERY_LONG_CYCLES : `RECOVERY_SHORT_CYCLES;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (count_reg == target_reg) begin
					busy_reg <= 1'b0;
					done <= 1'b1;
				end else begin
					count_reg <= count_reg + `RECOVERY_WIDTH'(1);
				end
			end
		end
	end

endmodule

/* File: src/watchdog_option_core.sv */
// watchdog counter with write-once option latches and stop-mode control
`timescale 1ns/100ps
`include "watchdog_regs.svh"

module watchdog_option_core
	import watchdog_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic internal_reset,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] reset_vector_low,
	input wire logic stop_instr,
	input wire logic stop_wake,
	input wire logic detector_reset_wake,
	input wire logic monitor_mode,
	input wire logic break_state,
	input wire logic test_high_voltage_reset_pin,
	input wire logic test_high_voltage_irq_pin,
	output logic watchdog_reset,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic watchdog_cause_set,
	output logic illegal_opcode,
	output logic stop_mode,
	output logic cpu_hold,
	output logic oscillator_run,
	output logic detector_run,
	output logic serial_port_clock_source,
	output logic detector_reset_disable,
	output logic detector_power_disable,
	output logic detector_voltage_mode,
	output logic stop_enable
);

	// ----------------------------------------------------------------
	// option latches
	// ----------------------------------------------------------------
	byte_t latch_two_reg;
	byte_t latch_one_reg;
	logic two_written_reg;
	logic one_written_reg;
	logic vmode_reg;
	logic vmode_written_reg;

	logic wr_two;
	logic wr_one;
	logic wr_service;
	logic rd_hit_two;
	logic rd_hit_one;
	logic rd_hit_service;

	assign wr_two = bus_wr && (bus_addr == `ADDR_OPTION_LATCH_TWO);
	assign wr_one = bus_wr && (bus_addr == `ADDR_OPTION_LATCH_ONE);
	assign wr_service = bus_wr && (bus_addr == `ADDR_WATCHDOG_SERVICE);
	assign rd_hit_two = bus_rd && (bus_addr == `ADDR_OPTION_LATCH_TWO);
	assign rd_hit_one = bus_rd && (bus_addr == `ADDR_OPTION_LATCH_ONE);
	assign rd_hit_service = bus_rd && (bus_addr == `ADDR_WATCHDOG_SERVICE);

	// later writes fall through with no flag and no fault
	always_ff @(posedge clk_sys) begin
		if (!rst_n || internal_reset) begin
			latch_two_reg <= `OPTION_RESET_VALUE;
			two_written_reg <= 1'b0;
		end else if (ce) begin
			if (wr_two && !two_written_reg) begin
				latch_two_reg <= bus_wdata;
				two_written_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || internal_reset) begin
			latch_one_reg <= `OPTION_RESET_VALUE;
			one_written_reg <= 1'b0;
		end else if (ce) begin
			if (wr_one && !one_written_reg) begin
				latch_one_reg <= bus_wdata;
				one_written_reg <= 1'b1;
			end
		end
	end

	// voltage mode survives internal resets; only power-on clears it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			vmode_reg <= 1'b0;
			vmode_written_reg <= 1'b0;
		end else if (ce) begin
			if (wr_one && !vmode_written_reg) begin
				vmode_reg <= bus_wdata[`BIT_DETECTOR_VOLTAGE_MODE];
				vmode_written_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// option decode
	// ----------------------------------------------------------------
	logic rate_short;
	logic detector_stop_enable;
	logic short_recovery;
	logic watchdog_disable;
	logic osc_in_stop_enable;

	assign osc_in_stop_enable = latch_two_reg[`BIT_OSC_IN_STOP_ENABLE];
	assign serial_port_clock_source = latch_two_reg[`BIT_SERIAL_CLOCK_SOURCE];
	assign rate_short = latch_one_reg[`BIT_WATCHDOG_RATE_SELECT];
	assign detector_stop_enable = latch_one_reg[`BIT_DETECTOR_STOP_ENABLE];
	assign short_recovery = latch_one_reg[`BIT_SHORT_RECOVERY];
	assign stop_enable = latch_one_reg[`BIT_STOP_ENABLE];
	assign watchdog_disable = latch_one_reg[`BIT_WATCHDOG_DISABLE];

	// this part has the detector always reset-enabled, powered and in 3-V mode
	assign detector_reset_disable = `DETECTOR_TIED_VALUE;
	assign detector_power_disable = `DETECTOR_TIED_VALUE;
	assign detector_voltage_mode = vmode_reg & `VOLTAGE_MODE_IMPLEMENTED;

	byte_t latch_one_view;

	always_comb begin
		latch_one_view = latch_one_reg;
		latch_one_view[`BIT_DETECTOR_RESET_DISABLE] = detector_reset_disable;
		latch_one_view[`BIT_DETECTOR_POWER_DISABLE] = detector_power_disable;
		latch_one_view[`BIT_DETECTOR_VOLTAGE_MODE] = detector_voltage_mode;
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	// reads never touch state, so software may poll the latches freely
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bus_rdata <= `BYTE_ZERO;
		end else if (ce) begin
			if (rd_hit_two) begin
				bus_rdata <= latch_two_reg;
			end else if (rd_hit_one) begin
				bus_rdata <= latch_one_view;
			end else if (rd_hit_service) begin
				bus_rdata <= reset_vector_low;
			end else begin
				bus_rdata <= `BYTE_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// stop mode and recovery
	// ----------------------------------------------------------------
	power_mode_e mode_reg;
	logic recovery_start;
	logic recovery_long;
	logic recovery_done;
	logic stop_accept;

	assign stop_accept = stop_instr && stop_enable && (mode_reg == MODE_RUN);
	assign recovery_start = (mode_reg == MODE_STOP) && (stop_wake || detector_reset_wake);
	// a detector reset wake ignores the short setting
	assign recovery_long = !short_recovery || detector_reset_wake;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || internal_reset) begin
			illegal_opcode <= 1'b0;
		end else if (ce) begin
			illegal_opcode <= stop_instr && !stop_enable;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_reg <= MODE_RUN;
		end else if (ce) begin
			case (mode_reg)
				MODE_RUN: begin
					if (stop_accept) begin
						mode_reg <= MODE_STOP;
					end
				end
				MODE_STOP: begin
					if (recovery_start) begin
						mode_reg <= MODE_RECOVER;
					end
				end
				MODE_RECOVER: begin
					if (recovery_done) begin
						mode_reg <= MODE_RUN;
					end
				end
				default: begin
					mode_reg <= MODE_RUN;
				end
			endcase
		end
	end

	stop_recovery u_recovery (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.start(recovery_start),
		.use_long(recovery_long),
		.done(recovery_done)
	);

	assign stop_mode = (mode_reg == MODE_STOP);
	assign cpu_hold = (mode_reg != MODE_RUN);
	assign oscillator_run = !stop_mode || osc_in_stop_enable;
	assign detector_run = !stop_mode || detector_stop_enable;

	// ----------------------------------------------------------------
	// test-voltage pins
	// ----------------------------------------------------------------
	logic [`PIN_COUNT-1:0] tv_level;

	pin_sync u_pins (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.pin_async({test_high_voltage_irq_pin, test_high_voltage_reset_pin}),
		.pin_level(tv_level)
	);

	logic tv_reset;
	logic tv_irq;
	logic watchdog_off;

	assign tv_reset = tv_level[`PIN_RESET_IDX];
	assign tv_irq = tv_level[`PIN_IRQ_IDX];
	assign watchdog_off = watchdog_disable
		|| (monitor_mode && (tv_reset || tv_irq))
		|| (break_state && tv_reset);

	// ----------------------------------------------------------------
	// power-on prescaler clear
	// ----------------------------------------------------------------
	logic [`RECOVERY_WIDTH-1:0] por_count_reg;
	logic por_clear;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			por_count_reg <= '0;
			por_clear <= 1'b0;
		end else if (ce) begin
			por_clear <= 1'b0;
			if (por_count_reg != `POR_CLEAR_CYCLES) begin
				por_count_reg <= por_count_reg + `RECOVERY_WIDTH'(1);
				por_clear <= (por_count_reg == `POR_CLEAR_CYCLES - `RECOVERY_WIDTH'(1));
			end
		end
	end

	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	logic [`PRESCALER_WIDTH-1:0] prescaler_reg;
	logic [`COUNTER_WIDTH-1:0] counter_reg;
	logic [`CHAIN_WIDTH-1:0] chain;
	logic counting;
	logic timeout_hit;

	assign chain = {counter_reg, prescaler_reg};
	// counts in run and wait; stops with the crystal clock or while watchdog_off is set
	assign counting = oscillator_run && !watchdog_off;
	assign timeout_hit = rate_short
		? (chain[`SHORT_CHAIN_WIDTH-1:0] == `TIMEOUT_SHORT_CYCLES)
		: (chain == `TIMEOUT_LONG_CYCLES);

	always_ff @(posedge clk_sys) begin
		if (!rst_n || internal_reset) begin
			prescaler_reg <= '0;
		end else if (ce) begin
			if (stop_accept || por_clear) begin
				prescaler_reg <= '0;
			end else if (wr_service) begin
				// low stages are kept, so a period may run short by up to 15
				prescaler_reg <= prescaler_reg & `SERVICE_KEEP_MASK;
			end else if (counting) begin
				prescaler_reg <= prescaler_reg + `PRESCALER_WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || internal_reset) begin
			counter_reg <= '0;
		end else if (ce) begin
			if (wr_service) begin
				counter_reg <= '0;
			end else if (counting && (&prescaler_reg) && !stop_accept && !por_clear) begin
				counter_reg <= counter_reg + `COUNTER_WIDTH'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog reset and reset pin
	// ----------------------------------------------------------------
	logic [`COUNTER_WIDTH-1:0] pin_count_reg;
	logic fire;

	assign fire = timeout_hit && counting && !wr_service && (pin_count_reg == '0);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			watchdog_reset <= 1'b0;
			watchdog_cause_set <= 1'b0;
		end else if (ce) begin
			watchdog_reset <= fire;
			watchdog_cause_set <= fire;
		end
	end

	// pin timer is not cleared by the internal reset it causes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_count_reg <= '0;
		end else if (ce) begin
			if (fire) begin
				pin_count_reg <= `RESET_PIN_CYCLES;
			end else if (pin_count_reg != '0) begin
				pin_count_reg <= pin_count_reg - `COUNTER_WIDTH'(1);
			end
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = (pin_count_reg != '0);

endmodule

/* File: verification/watchdog_option_core_asserts.sv */
// port-level assertions for the watchdog core
`timescale 1ns/100ps

module watchdog_option_core_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic internal_reset,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic stop_instr,
	input wire logic stop_wake,
	input wire logic watchdog_reset,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic watchdog_cause_set,
	input wire logic illegal_opcode,
	input wire logic stop_mode,
	input wire logic cpu_hold,
	input wire logic detector_reset_disable,
	input wire logic detector_power_disable,
	input wire logic detector_voltage_mode,
	input wire logic stop_enable
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// pin low time, in crystal cycles
	// ----------------------------------------
	logic [7:0] oe_cnt_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oe_cnt_reg <= 8'h00;
		end else begin
			oe_cnt_reg <= reset_pin_oe ? oe_cnt_reg + {7'h00, ce} : 8'h00;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rdata_idle;
		!$past(bus_rd) |-> bus_rdata == 8'h00;
	endproperty
	property p_cause;
		watchdog_cause_set == watchdog_reset;
	endproperty
	property p_pulse;
		watchdog_reset |=> !watchdog_reset && reset_pin_oe;
	endproperty
	property p_pin_len;
		$fell(reset_pin_oe) |-> oe_cnt_reg == 8'h20;
	endproperty
	property p_pin_drive;
		reset_pin_out == 1'b0;
	endproperty
	property p_tied;
		{detector_reset_disable, detector_power_disable, detector_voltage_mode} == 3'h0;
	endproperty
	property p_illegal;
		stop_instr && ce && !stop_enable && !cpu_hold && !internal_reset |=> illegal_opcode;
	endproperty
	property p_stop_entry;
		stop_instr && ce && stop_enable && !cpu_hold |=> stop_mode && cpu_hold;
	endproperty
	property p_wake;
		stop_mode && stop_wake && ce |=> !stop_mode && cpu_hold;
	endproperty
	property p_latch_hold;
		$changed(stop_enable) |-> $past(bus_wr) || $past(internal_reset);
	endproperty

	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	a_cause: assert property (p_cause) else $error("cause flag not with reset");
	a_pulse: assert property (p_pulse) else $error("reset pulse shape wrong");
	a_pin_len: assert property (p_pin_len) else $error("reset pin low time wrong");
	a_pin_drive: assert property (p_pin_drive) else $error("reset pin driven high");
	a_tied: assert property (p_tied) else $error("detector option bits not zero");
	a_illegal: assert property (p_illegal) else $error("no illegal opcode");
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
	a_wake: assert property (p_wake) else $error("wake not into recovery");
	a_latch_hold: assert property (p_latch_hold) else $error("option changed unwritten");

	c_timeout: cover property (watchdog_reset);
	c_illegal: cover property (illegal_opcode);
	c_wake: cover property (stop_mode && stop_wake);
endmodule

/* File: verification/watchdog_option_core_tb.sv */
// self-checking bench for the watchdog core
`timescale 1ns/100ps
`include "watchdog_regs.svh"

module watchdog_option_core_tb;
	logic clk_sys, rst_n, ce, internal_reset, bus_wr, bus_rd, stop_instr, stop_wake;
	logic detector_reset_wake, monitor_mode, break_state, tv_rst, tv_irq;
	logic [15:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, rv_low, r;
	logic watchdog_reset, reset_pin_out, reset_pin_oe, watchdog_cause_set, illegal_opcode;
	logic stop_mode, cpu_hold, oscillator_run, detector_run, serial_port_clock_source;
	logic detector_reset_disable, detector_power_disable, detector_voltage_mode, stop_enable;
	logic [7:0] m_val[2];
	bit m_done[2];
	int error_cnt, n_checks, cyc, n;

	watchdog_option_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.internal_reset(internal_reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .reset_vector_low(rv_low),
		.stop_instr(stop_instr), .stop_wake(stop_wake), .detector_reset_wake(detector_reset_wake),
		.monitor_mode(monitor_mode), .break_state(break_state),
		.test_high_voltage_reset_pin(tv_rst), .test_high_voltage_irq_pin(tv_irq),
		.watchdog_reset(watchdog_reset), .reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe), .watchdog_cause_set(watchdog_cause_set),
		.illegal_opcode(illegal_opcode), .stop_mode(stop_mode), .cpu_hold(cpu_hold),
		.oscillator_run(oscillator_run), .detector_run(detector_run),
		.serial_port_clock_source(serial_port_clock_source),
		.detector_reset_disable(detector_reset_disable),
		.detector_power_disable(detector_power_disable),
		.detector_voltage_mode(detector_voltage_mode), .stop_enable(stop_enable));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("wrong value at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// the model keeps the first write per reset only; later ones are dropped
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		if (a[15:1] == 15'h000F && !m_done[a[0]]) begin
			m_val[a[0]] = d & (a[0] ? 8'hC7 : 8'h03);
			m_done[a[0]] = 1'b1;
		end
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk8(bus_rdata, a[15:1] == 15'h000F ? m_val[a[0]] :
			(a == `ADDR_WATCHDOG_SERVICE ? rv_low : 8'h00));
	endtask

	// one-cycle pulse: 0 internal reset, 1 stop, 2 wake, 3 detector wake
	task automatic strobe(input int k);
		@(posedge clk_sys);
		{internal_reset, stop_instr, stop_wake, detector_reset_wake} <= 4'h8 >> k;
		@(posedge clk_sys);
		{internal_reset, stop_instr, stop_wake, detector_reset_wake} <= 4'h0;
		#1;
		if (k == 0) begin
			m_val = '{8'h00, 8'h00};
			m_done = '{1'b0, 1'b0};
		end
	endtask

	task automatic run_watch(input int lim);
		n = 0;
		while (watchdog_reset !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	task automatic hold_len(input int lo, input int hi);
		n = 0;
		while (cpu_hold === 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk_rng(n, lo, hi);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard well above the ~46.5k cycles the sequence needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_n, internal_reset, bus_wr, bus_rd, stop_instr, stop_wake} = 6'h00;
		{detector_reset_wake, monitor_mode, break_state, tv_rst, tv_irq} = 5'h00;
		{ce, bus_addr, bus_wdata} = 25'h1000000;
		{cyc, error_cnt, n_checks} = '0;
		m_val = '{8'h00, 8'h00};
		m_done = '{1'b0, 1'b0};
		void'($urandom(32'h4BBD0698));
		rv_low = 8'($urandom);
		r = 8'($urandom);
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`ADDR_OPTION_LATCH_TWO);
		rd(`ADDR_OPTION_LATCH_ONE);
		rd(`ADDR_WATCHDOG_SERVICE);
		rd(16'h0020);
		strobe(1);
		chk8(8'(illegal_opcode), 8'h01);
		chk8(8'(stop_mode), 8'h00);
		wr(`ADDR_OPTION_LATCH_ONE, 8'hB8 | (r & 8'h40));
		wr(`ADDR_OPTION_LATCH_TWO, r & 8'h03);
		rd(`ADDR_OPTION_LATCH_ONE);
		chk8(serial_port_clock_source, {7'h00, r[0]});
		wr(`ADDR_OPTION_LATCH_ONE, 8'h03);
		wr(`ADDR_OPTION_LATCH_TWO, ~r);
		rd(`ADDR_OPTION_LATCH_ONE);
		rd(`ADDR_OPTION_LATCH_TWO);
		chk8(8'(stop_enable), 8'h00);
		wr(`ADDR_WATCHDOG_SERVICE, r);
		repeat (5000) @(posedge clk_sys);
		wr(`ADDR_WATCHDOG_SERVICE, ~r);
		repeat (8000) @(posedge clk_sys);
		rd(`ADDR_WATCHDOG_SERVICE);
		run_watch(500);
		chk_rng(n + 8002, 8160, 8180);
		chk8(8'(watchdog_cause_set), 8'h01);
		n = 0;
		while (reset_pin_oe === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk_rng(n, 32, 32);
		strobe(0);
		rd(`ADDR_OPTION_LATCH_ONE);
		wr(`ADDR_OPTION_LATCH_ONE, 8'h81);
		wr(`ADDR_WATCHDOG_SERVICE, r);
		run_watch(8400);
		chk_rng(n, 8400, 8400);
		strobe(0);
		wr(`ADDR_OPTION_LATCH_ONE, 8'h80);
		{monitor_mode, tv_irq} <= 2'h3;
		wr(`ADDR_WATCHDOG_SERVICE, r);
		run_watch(8400);
		chk_rng(n, 8400, 8400);
		{monitor_mode, tv_irq} <= 2'h0;
		strobe(0);
		wr(`ADDR_OPTION_LATCH_TWO, 8'h02);
		wr(`ADDR_OPTION_LATCH_ONE, 8'h46);
		strobe(1);
		chk8(8'({stop_mode, cpu_hold}), 8'h03);
		chk8(8'(oscillator_run), 8'h01);
		chk8(8'(detector_run), 8'h01);
		repeat (4) @(posedge clk_sys);
		strobe(2);
		hold_len(31, 36);
		strobe(1);
		strobe(3);
		hold_len(4095, 4100);
		strobe(0);
		wr(`ADDR_OPTION_LATCH_ONE, 8'h02);
		strobe(1);
		chk8(8'(oscillator_run), 8'h00);
		chk8(8'(detector_run), 8'h00);
		strobe(2);
		hold_len(4095, 4100);
		// stop wipes the kept low stages too, so the period is full from the stop edge
		strobe(0);
		wr(`ADDR_OPTION_LATCH_TWO, 8'h02);
		wr(`ADDR_OPTION_LATCH_ONE, 8'h82);
		wr(`ADDR_WATCHDOG_SERVICE, r);
		strobe(1);
		run_watch(8300);
		chk_rng(n, 8176, 8178);
		conclude();
	end
endmodule

bind watchdog_option_core watchdog_option_core_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.ce(ce), .internal_reset(internal_reset), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .stop_instr(stop_instr), .stop_wake(stop_wake),
	.watchdog_reset(watchdog_reset), .reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe), .watchdog_cause_set(watchdog_cause_set),
	.illegal_opcode(illegal_opcode), .stop_mode(stop_mode), .cpu_hold(cpu_hold),
	.detector_reset_disable(detector_reset_disable),
	.detector_power_disable(detector_power_disable),
	.detector_voltage_mode(detector_voltage_mode), .stop_enable(stop_enable));
